// ---- hdl/pt8_defs.svh ----
/*
  Constants for the 8-bit period timer: control field positions, reset values and scaler codes.
  Assumes it is included by bare name from the prescaler and timer modules.
*/
// Notes on behaviour
// - Count instruction clock through 1/4/16 prescaler
// - Count up, wrap to zero after period match
// - Period register read/write, resets to FFh
// - Postscaler 1..16 on matches sets flag
// - Clearing run bit stops counting
// - Count register read/write, reset clears it
// - Scalers clear on count/control write, reset
// - Control write leaves count value alone
// - Count and match exported for PWM
// - Prescale 00=1, 01=4, 1x=16
// - Postscale divides by select value plus one
// - Pre-postscaler match goes to serial port
`ifndef PT8_DEFS_SVH
`define PT8_DEFS_SVH
`define PT8_CTL_PRE_LSB   0
`define PT8_CTL_RUN_BIT   2
`define PT8_CTL_POST_LSB  3
`define PT8_CTL_POST_MSB  6
`define PT8_CTL_RST       8'h00
`define PT8_COUNT_RST     8'h00
`define PT8_LIMIT_RST     8'hff
`define PT8_FLAG_BIT      1
`define PT8_INSTR_DIV     2'h3
`define PT8_PRE_DIV4_MAX  4'h3
`define PT8_PRE_DIV16_MAX 4'hf
`endif

// ---- hdl/pt8_pkg.sv ----
/*
  Types for the 8-bit period timer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package pt8_pkg;
  typedef logic [7:0] pt8_byte_t;
endpackage
`default_nettype wire

// ---- hdl/pt8_prescaler.sv ----
/*
  Input prescaler: turns instruction-clock ticks into counter ticks at 1, 4 or 16.
  Assumes tick_i is a one-cycle pulse and clr_i a synchronous clear.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pt8_defs.svh"
module pt8_prescaler (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       clr_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] top;

  // Terminal value for the selected ratio; any code with the upper bit set means sixteen.
  always_comb begin
    if (sel_i[1]) begin
      top = `PT8_PRE_DIV16_MAX;
    end else if (sel_i[0]) begin
      top = `PT8_PRE_DIV4_MAX;
    end else begin
      top = 4'h0;
    end
    cnt_nxt = cnt_r;
    tick_o  = 1'b0;
    if (clr_i) begin
      cnt_nxt = 4'h0;
    end else if (tick_i) begin
      if (cnt_r >= top) begin
        cnt_nxt = 4'h0;
        tick_o  = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  // Count register only.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // At ratio one every accepted instruction tick must pass straight through.
  a_pre_div_one: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (sel_i == 2'h0 && tick_i && !clr_i) |-> tick_o)
    else $error("prescaler dropped a tick");
endmodule // pt8_prescaler
`default_nettype wire

// ---- hdl/pt8_timer.sv ----
/*
  8-bit period timer with input prescaler, period compare and output postscaler.
  Assumes register writes arrive as one-cycle strobes synchronous to clk_sys_i, and
  that software clears the match flag with flag_clr_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pt8_defs.svh"
module pt8_timer (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        count_wr_i,
  input  wire logic [7:0]  count_wdata_i,
  input  wire logic        limit_wr_i,
  input  wire logic [7:0]  limit_wdata_i,
  input  wire logic        ctrl_wr_i,
  input  wire logic [7:0]  ctrl_wdata_i,
  input  wire logic        flag_clr_i,
  output logic      [7:0]  period_count_reg_o,
  output logic      [7:0]  period_limit_reg_o,
  output logic      [7:0]  period_timer_control_o,
  output logic             period_match_flag_o,
  output logic             pwm_match_o,
  output logic             sync_serial_port_tick_o
);
  logic               rst_s1_r;
  logic               rst_s2_r;
  logic               rst_n;
  logic [1:0]         instr_r;
  logic [1:0]         instr_nxt;
  logic               instr_tick;
  logic               pre_tick;
  logic               scaler_clr;
  pt8_pkg::pt8_byte_t count_r;
  pt8_pkg::pt8_byte_t count_nxt;
  pt8_pkg::pt8_byte_t limit_r;
  pt8_pkg::pt8_byte_t limit_nxt;
  logic [6:0]         ctrl_r;
  logic [6:0]         ctrl_nxt;
  logic [3:0]         post_r;
  logic [3:0]         post_nxt;
  logic               flag_r;
  logic               flag_nxt;
  logic               match_r;
  logic               match_nxt;
  logic               hit;

  // Field decoders shared by the datapath and the checks; bit positions live in one place.
  function automatic logic [3:0] post_select(input logic [6:0] ctrl);
    return ctrl[`PT8_CTL_POST_MSB:`PT8_CTL_POST_LSB];
  endfunction

  function automatic logic run_enabled(input logic [6:0] ctrl);
    return ctrl[`PT8_CTL_RUN_BIT];
  endfunction

  // Reset release passes through two flops so it leaves every register on the same edge.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // Instruction clock is the system clock divided by four; it runs even when stopped.
  assign instr_tick = (instr_r == `PT8_INSTR_DIV);
  assign instr_nxt  = instr_r + 2'h1;
  assign scaler_clr = count_wr_i | ctrl_wr_i;

  pt8_prescaler pt8_prescaler_i (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .clr_i     (scaler_clr),
    .tick_i    (instr_tick & run_enabled(ctrl_r)),
    .sel_i     (ctrl_r[`PT8_CTL_PRE_LSB +: 2]),
    .tick_o    (pre_tick)
  );

  // A counter tick at the period value is the match; it wraps instead of advancing.
  assign hit = pre_tick & ~count_wr_i & (count_r == limit_r);

  // Next state for count, period, control, postscaler and flag.
  always_comb begin
    count_nxt = count_r;
    if (count_wr_i) begin
      count_nxt = count_wdata_i;
    end else if (hit) begin
      count_nxt = `PT8_COUNT_RST;
    end else if (pre_tick) begin
      count_nxt = count_r + 8'h01;
    end
    limit_nxt = limit_wr_i ? limit_wdata_i : limit_r;
    ctrl_nxt  = ctrl_wr_i ? ctrl_wdata_i[6:0] : ctrl_r;
    match_nxt = hit;
    post_nxt  = post_r;
    flag_nxt  = flag_r & ~flag_clr_i;
    if (scaler_clr) begin
      post_nxt = 4'h0;
    end else if (hit) begin
      // Postscaler terminal value is the select code itself, so 0 gives one, 15 gives sixteen.
      if (post_r >= post_select(ctrl_r)) begin
        post_nxt = 4'h0;
        flag_nxt = 1'b1;
      end else begin
        post_nxt = post_r + 4'h1;
      end
    end
  end

  // Register stage; every output below is one of these flops.
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      instr_r <= 2'h0;
      count_r <= `PT8_COUNT_RST;
      limit_r <= `PT8_LIMIT_RST;
      ctrl_r  <= 7'(`PT8_CTL_RST); // Bit 7 is not stored, so the reset value is cut to seven bits.
      post_r  <= 4'h0;
      flag_r  <= 1'b0;
      match_r <= 1'b0;
    end else begin
      instr_r <= instr_nxt;
      count_r <= count_nxt;
      limit_r <= limit_nxt;
      ctrl_r  <= ctrl_nxt;
      post_r  <= post_nxt;
      flag_r  <= flag_nxt;
      match_r <= match_nxt;
    end
  end

  // Outputs: control reads bit 7 as zero; match pulse feeds PWM and serial port.
  assign period_count_reg_o     = count_r;
  assign period_limit_reg_o     = limit_r;
  assign period_timer_control_o = {1'b0, ctrl_r};
  assign period_match_flag_o    = flag_r;
  assign pwm_match_o            = match_r;
  assign sync_serial_port_tick_o = match_r;

  // Steps of the write, flag and stop behaviour, shared by the checks below.
  sequence s_ctrl_write;
    ctrl_wr_i && !count_wr_i;
  endsequence

  sequence s_flag_clear_alone;
    flag_clr_i && !hit;
  endsequence

  sequence s_flag_rise;
    !flag_r ##1 flag_r;
  endsequence

  sequence s_stopped;
    !run_enabled(ctrl_r);
  endsequence

  // Register writes land one cycle later and beat anything else on that cycle.
  a_ctrl_keeps_count: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_ctrl_write |=> (count_r == $past(count_r)))
    else $error("control write moved count");
  a_count_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    count_wr_i |=> (count_r == $past(count_wdata_i)))
    else $error("count write lost");
  a_write_beats_match: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    count_wr_i |=> !match_r)
    else $error("match despite count write");
  a_limit_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    limit_wr_i |=> (limit_r == $past(limit_wdata_i)))
    else $error("period write lost");
  a_limit_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    !limit_wr_i |=> $stable(limit_r))
    else $error("period value drifted");

  // Counting, wrapping and the match pulse.
  a_wrap_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    match_r |-> (count_r == 8'h00))
    else $error("match did not wrap to zero");
  a_match_at_limit: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    match_r |-> ($past(count_r) == $past(limit_r)))
    else $error("wrap away from period value");
  // Without a write the count may only hold, step by one or wrap to zero.
  a_count_steps: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    !count_wr_i |=> (count_r == $past(count_r) || count_r == $past(count_r) + 8'h01 ||
      count_r == `PT8_COUNT_RST))
    else $error("count jumped");
  // Instruction ticks are four clocks apart, so a match pulse is followed by three idle cycles.
  a_match_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    match_r |=> (!match_r)[*3])
    else $error("match pulse too long");
  a_full_speed: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (ctrl_r[2:0] == 3'h4 && !ctrl_wr_i && !count_wr_i && count_r != limit_r && instr_tick)
    |=> (count_r == $past(count_r) + 8'h01))
    else $error("1:1 tick missed");
  a_serial_tick: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    hit |=> sync_serial_port_tick_o)
    else $error("serial tick missing");

  // A stopped timer neither moves nor matches, which is what saves the power.
  a_stopped_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (!ctrl_r[2] && !count_wr_i) |=> (count_r == $past(count_r)))
    else $error("stopped timer moved");
  a_stopped_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_stopped |=> !match_r)
    else $error("match while stopped");

  // Postscaler and flag; a set on the same cycle as a clear must win.
  a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (flag_r && !flag_clr_i) |=> flag_r)
    else $error("flag dropped");
  a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_flag_clear_alone |=> !flag_r)
    else $error("flag clear ignored");
  a_flag_source: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_flag_rise |-> $past(hit))
    else $error("flag set without match");
  a_flag_post1: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (hit && !scaler_clr && ctrl_r[6:3] == 4'h0) |=> flag_r)
    else $error("1:1 postscale missed");
  // Clears on control writes keep the postscaler at or below its select code.
  a_post_bounded: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    post_r <= post_select(ctrl_r))
    else $error("postscaler past its select");
  a_scaler_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    scaler_clr |=> (post_r == 4'h0))
    else $error("postscaler not cleared");
endmodule // pt8_timer
`default_nettype wire

// ---- testbench/pt8_timer_bench.sv ----
/*
  Self-checking bench for the 8-bit period timer, driving its write strobes directly.
  Assumes the design files under hdl/ are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module pt8_timer_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cw = 1'b0, lw = 1'b0, kw = 1'b0, fc = 1'b0;
  logic [7:0]  cd = 8'h00, ld = 8'h00, kd = 8'h00;
  logic [7:0]  cnt, lim, ctl;
  logic        flag, pwm, stk;
  logic [15:0] n, k, v;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          divs [4] = '{1, 4, 16, 16};
  int          posts [3] = '{0, 2, 15};

  // 40 MHz system clock.
  always #12.5 clk = ~clk;

  pt8_timer pt8_timer_i (.clk_sys_i(clk), .rst_n_i(rst_n), .count_wr_i(cw),
    .count_wdata_i(cd), .limit_wr_i(lw), .limit_wdata_i(ld), .ctrl_wr_i(kw),
    .ctrl_wdata_i(kd), .flag_clr_i(fc), .period_count_reg_o(cnt),
    .period_limit_reg_o(lim), .period_timer_control_o(ctl),
    .period_match_flag_o(flag), .pwm_match_o(pwm), .sync_serial_port_tick_o(stk));

  // Prints the counts and the verdict, then stops the run.
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle write strobe: 0 count, 1 limit, 2 control; ends after the taking edge.
  task wr(input int sel, input logic [7:0] d);
    @(negedge clk);
    cw = (sel == 0);
    lw = (sel == 1);
    kw = (sel == 2);
    cd = d;
    ld = d;
    kd = d;
    @(negedge clk);
    cw = 1'b0;
    lw = 1'b0;
    kw = 1'b0;
  endtask

  // Counts clocks up to the next match pulse; bounded so a dead timer cannot hang.
  task period(output logic [15:0] c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (pwm !== 1'b1 && c < 16'd2000);
    chk("shift tick", 16'h1, 16'(stk));
  endtask

  // The run stops here if the tests take far longer than their ~2000 clocks.
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    $display("watchdog ran out");
    end_of_test;
  end

  // Main sequence; inputs change only at falling edges.
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("count reset", 16'h0, 16'(cnt));
    chk("limit reset", 16'hff, 16'(lim));
    chk("control reset", 16'h0, 16'(ctl));
    chk("flag reset", 16'h0, 16'(flag));
    $display("test reset done");
    // Wrap period is (limit + 1) * 4 clocks * prescale for every select code.
    wr(1, 8'h03);
    chk("limit", 16'h3, 16'(lim));
    for (int s = 0; s < 4; s++) begin
      wr(2, 8'h04 | 8'(s));
      period(n);
      period(n);
      chk("period", 16'(16 * divs[s]), n);
    end
    $display("test prescale done");
    // Postscaler: from a cleared start, the flag rises on match number select + 1.
    for (int p = 0; p < 3; p++) begin
      wr(2, 8'h00);
      fc = 1'b1;
      @(negedge clk);
      fc = 1'b0;
      chk("flag cleared", 16'h0, 16'(flag));
      wr(0, 8'h00);
      wr(2, {1'b0, 4'(posts[p]), 3'b100});
      k = 0;
      do begin
        period(n);
        k++;
      end while (flag !== 1'b1 && k < 16'd20);
      chk("matches to flag", 16'(posts[p] + 1), k);
    end
    $display("test postscale done");
    // A count write lands on a cycle with no increment and holds while stopped.
    wr(1, 8'hff);
    wr(2, 8'h04);
    wr(0, 8'h55);
    chk("count write", 16'h55, 16'(cnt));
    wr(2, 8'h00);
    v = 16'(cnt);
    repeat (40) @(negedge clk);
    chk("stopped count", v, 16'(cnt));
    wr(2, 8'hf8);
    chk("count after control write", v, 16'(cnt));
    chk("control read", 16'h78, 16'(ctl));
    $display("test stop done");
    // Count writes every 42 clocks at 1:16 must keep clearing the prescaler.
    wr(2, 8'h06);
    repeat (8) begin
      wr(0, 8'h00);
      repeat (40) @(negedge clk);
      chk("prescaler cleared", 16'h0, 16'(cnt));
    end
    $display("test scaler clear done");
    // A reset in mid-run, with the timer running and the flag set, must restore every register.
    wr(1, 8'h80);
    wr(0, 8'h42);
    chk("count before reset", 16'h42, 16'(cnt));
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("count mid reset", 16'h0, 16'(cnt));
    chk("limit mid reset", 16'hff, 16'(lim));
    chk("control mid reset", 16'h0, 16'(ctl));
    chk("flag mid reset", 16'h0, 16'(flag));
    $display("test mid reset done");
    end_of_test;
  end
endmodule // pt8_timer_bench
`default_nettype wire
